// ===== logic/pa_pkg.sv
// Shared constants and types for the process alarm and I/O function block.
// Assumes a 200 MHz core clock and an APB master with 32-bit data.
package pa_pkg;
	// Register byte addresses
	localparam logic [7:0] PA_ADDR_CTRL = 8'h00;
	localparam logic [7:0] PA_ADDR_IOFUNC = 8'h04;
	localparam logic [7:0] PA_ADDR_SETPT = 8'h08;
	localparam logic [7:0] PA_ADDR_TUNE = 8'h0C;
	localparam logic [7:0] PA_ADDR_ALCFG0 = 8'h10;
	localparam logic [7:0] PA_ADDR_ALTIM0 = 8'h20;
	localparam logic [7:0] PA_ADDR_STATUS = 8'h30;
	// Control register bit positions
	localparam int PA_CTRL_RUN = 0;
	localparam int PA_CTRL_MANUAL = 1;
	localparam int PA_CTRL_EXTRA_IO = 2;
	localparam logic [31:0] PA_CTRL_RESET = 32'h0000_0001;
	// Timing
	localparam int PA_CLK_HZ = 200_000_000;
	localparam int PA_TICK_S = 1;
	localparam int PA_TICK_CYCLES = PA_CLK_HZ * PA_TICK_S;
	localparam logic [12:0] PA_TIME_MAX = 13'h1964;
	// Power scale in tenths of a percent
	localparam logic [9:0] PA_POWER_FULL = 10'h3E8;
	localparam logic [9:0] PA_POWER_ZERO = 10'h000;
	localparam int PA_CHANNELS = 5;
	localparam int PA_ALARMS = 4;
	localparam int PA_SEGMENTS = 9;

	typedef enum logic [2:0] {
		PA_AF_OFF = 3'h0,
		PA_AF_FAULT = 3'h1,
		PA_AF_EVENT = 3'h2,
		PA_AF_LOW = 3'h3,
		PA_AF_HIGH = 3'h4,
		PA_AF_BAND = 3'h5,
		PA_AF_DEV_LOW = 3'h6,
		PA_AF_DEV_HIGH = 3'h7
	} pa_alarm_func_type;

	typedef enum logic [3:0] {
		PA_IO_OFF = 4'h0,
		PA_IO_AL1 = 4'h1,
		PA_IO_AL2 = 4'h2,
		PA_IO_AL3 = 4'h3,
		PA_IO_AL4 = 4'h4,
		PA_IO_LOOP_BREAK = 4'h5,
		PA_IO_CTL1 = 4'h6,
		PA_IO_CTL2 = 4'h7,
		PA_IO_DI_AUTO_MAN = 4'h8,
		PA_IO_DI_RUN = 4'h9,
		PA_IO_DI_REMOTE = 4'hA,
		PA_IO_DI_HOLD = 4'hB,
		PA_IO_DI_PROG1 = 4'hC,
		PA_IO_AN_CTL1 = 4'hD,
		PA_IO_AN_CTL2 = 4'hE,
		PA_IO_AN_RETX = 4'hF
	} pa_io_func_type;

	// Gray sequence idle, wait, on, rest, spent
	typedef enum logic [2:0] {
		PA_TS_IDLE = 3'b000,
		PA_TS_WAIT = 3'b001,
		PA_TS_ON = 3'b011,
		PA_TS_REST = 3'b010,
		PA_TS_SPENT = 3'b110
	} pa_timer_state_type;

	typedef struct packed {
		logic signed [15:0] alarm_threshold;
		logic [2:0] pad;
		logic [8:0] seg_mask;
		logic init_block;
		pa_alarm_func_type func;
	} pa_alarm_cfg_type;

	typedef struct packed {
		logic [15:0] delay_time;
		logic [15:0] pulse_time;
	} pa_alarm_time_type;
endpackage : pa_pkg

// ===== logic/pa_alarm_io.sv
// Alarm evaluation, alarm timers, digital-input functions and control power selection.
// Assumes synchronous inputs, an APB master, and an external PID engine and profile engine.
//
// Overview of operation
// - Auto/manual input closed selects manual control, open selects automatic.
// - Run input closed enables control and alarm outputs, open forces them off.
// - Remote setpoint input closed uses remote setpoint, open uses main setpoint.
// - Hold input open freezes profile, control continues at frozen setpoint.
// - Program-one input closed runs profile one, open uses main setpoint.
// - Analog control and retransmission functions exist only on channel five.
// - Pulse control only on channel five, or three and four with option.
// - Loop-break alarm may be routed to any channel.
// - Four alarms, each with one of eight functions.
// - Alarm set off never drives its output.
// - Sensor fault alarm on open input, out of range, or shorted thermometer.
// - Program event alarm active only in chosen segments of running profile.
// - Low alarm below threshold, high alarm above threshold.
// - Band alarm outside band for positive threshold, inside for negative.
// - Deviation-below alarm when value under setpoint minus threshold.
// - Deviation-above alarm when value over setpoint plus threshold.
// - Two timers select direct, single pulse, delayed, or repeated pulsing.
// - Alarm lamp follows raw condition regardless of output timing.
// - Initial blocking ignores power-up condition until it clears and returns.
// - Initial blocking never applies to sensor fault alarms.
// - Automatic mode computes power, manual applies user power, parameter selects.
// - Full PID only on output one, output two proportional only.
// - Zero proportional band gives on/off control at zero or full power.
`timescale 1ns/1ps
module pa_alarm_io import pa_pkg::*; #(
	parameter int TICK_CYCLES = PA_TICK_CYCLES
) (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic signed [15:0] process_value,
	input wire logic sensor_open,
	input wire logic sensor_range,
	input wire logic sensor_short,
	input wire logic signed [15:0] profile_setpoint,
	input wire logic profile_running,
	input wire logic [3:0] profile_segment,
	input wire logic [9:0] pid_power,
	input wire logic loop_break,
	input wire logic [4:0] di_closed,
	output logic [4:0] ch_drive,
	output logic [4:0] ch_pulse_mode,
	output logic [3:0] analog_func,
	output logic [3:0] alarm_lamp,
	output logic [9:0] power_one,
	output logic [9:0] power_two,
	output logic signed [15:0] control_setpoint,
	output logic manual_active,
	output logic profile_hold,
	output logic first_profile_select
);
	logic [31:0] ctrl;
	logic [19:0] io_func_reg;
	logic signed [15:0] main_setpoint;
	logic signed [15:0] remote_setpoint;
	logic [15:0] proportional_band;
	logic [9:0] manual_power;
	pa_alarm_cfg_type alarm_cfg [PA_ALARMS];
	pa_alarm_time_type alarm_time [PA_ALARMS];
	logic [31:0] tick_cnt;
	logic tick;

	// APB decode; zero wait states, answer registered in the setup cycle
	wire setup_phase = psel & ~penable;
	wire write_go = psel & penable & pready & pwrite & ~pslverr;
	wire addr_alcfg = (paddr[7:4] == PA_ADDR_ALCFG0[7:4]) & (paddr[1:0] == 2'h0);
	wire addr_altim = (paddr[7:4] == PA_ADDR_ALTIM0[7:4]) & (paddr[1:0] == 2'h0);
	wire [1:0] al_sel = paddr[3:2];
	wire addr_known = (paddr == PA_ADDR_CTRL) | (paddr == PA_ADDR_IOFUNC) | (paddr == PA_ADDR_SETPT) |
		(paddr == PA_ADDR_TUNE) | (paddr == PA_ADDR_STATUS) | addr_alcfg | addr_altim;

	// One-second enable; long divider kept a parameter so benches can shorten it
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			tick_cnt <= '0;
			tick <= 1'b0;
		end else begin
			tick <= (tick_cnt == TICK_CYCLES - 1);
			tick_cnt <= (tick_cnt == TICK_CYCLES - 1) ? '0 : tick_cnt + 32'd1;
		end
	end

	// Channel function legality; an illegal code acts as no function
	function automatic logic func_legal(input int ch, input logic [3:0] code, input logic extra);
		logic di_ch;
		di_ch = (ch == 4) | (extra & ((ch == 2) | (ch == 3)));
		if (code >= PA_IO_AN_CTL1)
			return ch == 4;
		else if (code >= PA_IO_DI_AUTO_MAN)
			return di_ch;
		else
			return 1'b1;
	endfunction

	logic [3:0] eff_func [PA_CHANNELS];
	logic [4:0] di_cfg_am, di_cfg_run, di_cfg_rsp, di_cfg_hold, di_cfg_pr1;
	genvar gc;
	generate
		for (gc = 0; gc < PA_CHANNELS; gc++) begin : g_chan
			assign eff_func[gc] = func_legal(gc, io_func_reg[gc*4 +: 4], ctrl[PA_CTRL_EXTRA_IO]) ?
				io_func_reg[gc*4 +: 4] : PA_IO_OFF;
			assign di_cfg_am[gc] = eff_func[gc] == PA_IO_DI_AUTO_MAN;
			assign di_cfg_run[gc] = eff_func[gc] == PA_IO_DI_RUN;
			assign di_cfg_rsp[gc] = eff_func[gc] == PA_IO_DI_REMOTE;
			assign di_cfg_hold[gc] = eff_func[gc] == PA_IO_DI_HOLD;
			assign di_cfg_pr1[gc] = eff_func[gc] == PA_IO_DI_PROG1;
		end
	endgenerate

	// Digital-input functions; with no input assigned the parameter rules
	wire next_manual = |di_cfg_am ? |(di_cfg_am & di_closed) : ctrl[PA_CTRL_MANUAL];
	wire run_on = ctrl[PA_CTRL_RUN] & (~|di_cfg_run | |(di_cfg_run & di_closed));
	wire use_remote = |(di_cfg_rsp & di_closed);
	wire next_hold = |di_cfg_hold & ~|(di_cfg_hold & di_closed);
	wire next_prog1 = |(di_cfg_pr1 & di_closed);
	// Profile keeps driving its frozen point while held, so control follows it
	wire signed [15:0] next_setpoint = next_prog1 ? profile_setpoint :
		(use_remote ? remote_setpoint : main_setpoint);

	// Control power; the PID engine sits outside and only feeds output one
	wire pb_zero = proportional_band == 16'h0000;
	wire signed [16:0] dev_cool = 17'(process_value) - 17'(control_setpoint);
	wire [31:0] prop_raw = pb_zero ? 32'h0 : (32'(dev_cool[15:0]) * 32'(PA_POWER_FULL)) / 32'(proportional_band);
	wire [9:0] auto_one = pb_zero ? ((control_setpoint > process_value) ? PA_POWER_FULL : PA_POWER_ZERO) :
		pid_power;
	wire [9:0] auto_two = (dev_cool <= 17'sh0) ? PA_POWER_ZERO : (pb_zero ? PA_POWER_FULL :
		((prop_raw > 32'(PA_POWER_FULL)) ? PA_POWER_FULL : prop_raw[9:0]));
	wire [9:0] next_power_one = ~run_on ? PA_POWER_ZERO : (manual_active ? manual_power : auto_one);
	wire [9:0] next_power_two = (~run_on | manual_active) ? PA_POWER_ZERO : auto_two;

	// Alarm evaluation, blocking and timers, one slice per alarm
	logic [3:0] raw_cond;
	logic [3:0] alarm_out;
	logic [3:0] blocked;
	wire sensor_fault_alarm = sensor_open | sensor_range | sensor_short;
	genvar ga;
	generate
		for (ga = 0; ga < PA_ALARMS; ga++) begin : g_alarm
			pa_timer_state_type tstate, next_tstate;
			logic [12:0] tcount;
			wire signed [16:0] thr = 17'(alarm_cfg[ga].alarm_threshold);
			wire signed [16:0] pv = 17'(process_value);
			wire signed [16:0] sp_lo = 17'(control_setpoint) - thr;
			wire signed [16:0] sp_hi = 17'(control_setpoint) + thr;
			wire in_band = (thr >= 17'sh0) ? (pv >= sp_lo && pv <= sp_hi) : (pv >= sp_hi && pv <= sp_lo);
			wire seg_hit = (profile_segment < 4'(PA_SEGMENTS)) && alarm_cfg[ga].seg_mask[profile_segment];
			wire [12:0] t1 = alarm_cfg[ga].func == PA_AF_OFF ? 13'h0 :
				(alarm_time[ga].pulse_time > 16'(PA_TIME_MAX) ? PA_TIME_MAX : alarm_time[ga].pulse_time[12:0]);
			wire [12:0] t2 = alarm_time[ga].delay_time > 16'(PA_TIME_MAX) ? PA_TIME_MAX :
				alarm_time[ga].delay_time[12:0];
			wire can_block = alarm_cfg[ga].init_block & (alarm_cfg[ga].func != PA_AF_FAULT);
			wire effective = raw_cond[ga] & ~(blocked[ga] & can_block);
			wire t1_done = tick & (tcount >= t1);
			wire t2_done = tick & (tcount >= t2);

			// Condition per function
			always_comb begin
				unique case (alarm_cfg[ga].func)
					PA_AF_OFF: raw_cond[ga] = 1'b0;
					PA_AF_FAULT: raw_cond[ga] = sensor_fault_alarm;
					PA_AF_EVENT: raw_cond[ga] = profile_running & seg_hit;
					PA_AF_LOW: raw_cond[ga] = pv < thr;
					PA_AF_HIGH: raw_cond[ga] = pv > thr;
					PA_AF_BAND: raw_cond[ga] = (thr >= 17'sh0) ? ~in_band : in_band;
					PA_AF_DEV_LOW: raw_cond[ga] = pv < sp_lo;
					PA_AF_DEV_HIGH: raw_cond[ga] = pv > sp_hi;
				endcase
			end

			// Timer sequencing; a zero delay skips wait and rest, a zero pulse time holds the output on
			always_comb begin
				next_tstate = tstate;
				if (!effective)
					next_tstate = PA_TS_IDLE;
				else begin
					unique case (tstate)
						PA_TS_IDLE: next_tstate = (t2 != 13'h0 && t1 == 13'h0) ? PA_TS_WAIT : PA_TS_ON;
						PA_TS_WAIT: if (t2_done) next_tstate = PA_TS_ON;
						PA_TS_ON: if (t1 != 13'h0 && t1_done)
							next_tstate = (t2 != 13'h0) ? PA_TS_REST : PA_TS_SPENT;
						PA_TS_REST: if (t2_done) next_tstate = PA_TS_ON;
						PA_TS_SPENT: next_tstate = PA_TS_SPENT;
						default: next_tstate = PA_TS_IDLE;
					endcase
				end
			end

			// Blocked from power-up until the condition first clears
			always_ff @(posedge clk) begin
				if (!rst_b) begin
					tstate <= PA_TS_IDLE;
					tcount <= 13'h0;
					blocked[ga] <= 1'b1;
				end else begin
					tstate <= next_tstate;
					tcount <= (next_tstate != tstate) ? 13'h0 : (tick ? tcount + 13'h1 : tcount);
					if (!raw_cond[ga])
						blocked[ga] <= 1'b0;
				end
			end
			// Off gates at once; waiting for the timer state to drop would leak a cycle
			assign alarm_out[ga] = (tstate == PA_TS_ON) & run_on & (alarm_cfg[ga].func != PA_AF_OFF);
		end
	endgenerate

	// Channel drive and pulse capability
	logic [4:0] next_drive, next_pulse;
	generate
		for (gc = 0; gc < PA_CHANNELS; gc++) begin : g_drive
			wire [3:0] f = eff_func[gc];
			assign next_drive[gc] = (f >= PA_IO_AL1 && f <= PA_IO_AL4) ? alarm_out[2'(f - 4'h1)] :
				(f == PA_IO_LOOP_BREAK) ? loop_break & run_on :
				(f == PA_IO_CTL1) ? power_one != PA_POWER_ZERO :
				(f == PA_IO_CTL2) ? power_two != PA_POWER_ZERO : 1'b0;
			// Relay works anywhere; the fast pulse driver exists only on these pins
			assign next_pulse[gc] = ((f == PA_IO_CTL1) | (f == PA_IO_CTL2)) &
				((gc == 4) | (ctrl[PA_CTRL_EXTRA_IO] & ((gc == 2) | (gc == 3))));
		end
	endgenerate
	wire [3:0] next_analog = (eff_func[4] >= PA_IO_AN_CTL1) ? eff_func[4] : PA_IO_OFF;

	// Read mux
	wire [31:0] status_word = {14'h0, next_prog1, next_hold, use_remote, manual_active, run_on,
		ch_drive, alarm_out, alarm_lamp};
	wire [31:0] read_word = (paddr == PA_ADDR_CTRL) ? ctrl :
		(paddr == PA_ADDR_IOFUNC) ? {12'h0, io_func_reg} :
		(paddr == PA_ADDR_SETPT) ? {remote_setpoint, main_setpoint} :
		(paddr == PA_ADDR_TUNE) ? {6'h0, manual_power, proportional_band} :
		addr_alcfg ? alarm_cfg[al_sel] & 32'hFFFF_1FFF :
		addr_altim ? alarm_time[al_sel] :
		(paddr == PA_ADDR_STATUS) ? status_word : 32'h0;

	// Register file and registered outputs
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			ctrl <= PA_CTRL_RESET;
			io_func_reg <= '0;
			main_setpoint <= '0;
			remote_setpoint <= '0;
			proportional_band <= '0;
			manual_power <= '0;
			for (int i = 0; i < PA_ALARMS; i++) begin
				alarm_cfg[i] <= '0;
				alarm_time[i] <= '0;
			end
			prdata <= '0;
			pready <= 1'b0;
			pslverr <= 1'b0;
		end else begin
			pready <= setup_phase;
			pslverr <= setup_phase & ~addr_known;
			prdata <= setup_phase & ~pwrite ? read_word : 32'h0;
			if (write_go) begin
				if (paddr == PA_ADDR_CTRL) ctrl <= pwdata & 32'h0000_0007;
				if (paddr == PA_ADDR_IOFUNC) io_func_reg <= pwdata[19:0];
				if (paddr == PA_ADDR_SETPT) {remote_setpoint, main_setpoint} <= pwdata;
				if (paddr == PA_ADDR_TUNE) {manual_power, proportional_band} <= pwdata[25:0];
				if (addr_alcfg) alarm_cfg[al_sel] <= pwdata & 32'hFFFF_1FFF;
				if (addr_altim) alarm_time[al_sel] <= pwdata;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_b) begin
			ch_drive <= '0;
			ch_pulse_mode <= '0;
			analog_func <= '0;
			alarm_lamp <= '0;
			power_one <= '0;
			power_two <= '0;
			control_setpoint <= '0;
			manual_active <= 1'b0;
			profile_hold <= 1'b0;
			first_profile_select <= 1'b0;
		end else begin
			ch_drive <= next_drive;
			ch_pulse_mode <= next_pulse;
			analog_func <= next_analog;
			alarm_lamp <= raw_cond;
			power_one <= next_power_one;
			power_two <= next_power_two;
			control_setpoint <= next_setpoint;
			manual_active <= next_manual;
			profile_hold <= next_hold;
			first_profile_select <= next_prog1;
		end
	end

	// Checks
	a_run_off_power: assert property (@(posedge clk) disable iff (!rst_b)
		!run_on |=> (power_one == PA_POWER_ZERO && power_two == PA_POWER_ZERO))
		else $error("power not zero while stopped");
	a_manual_power: assert property (@(posedge clk) disable iff (!rst_b)
		(run_on && manual_active) |=> power_one == $past(manual_power))
		else $error("manual power not applied");
	a_onoff_full: assert property (@(posedge clk) disable iff (!rst_b)
		(run_on && !manual_active && pb_zero && control_setpoint > process_value) |=> power_one == PA_POWER_FULL)
		else $error("on/off control not full");
	a_lamp_raw: assert property (@(posedge clk) disable iff (!rst_b)
		##1 alarm_lamp == $past(raw_cond))
		else $error("lamp not following condition");
	a_off_silent: assert property (@(posedge clk) disable iff (!rst_b)
		(alarm_cfg[0].func == PA_AF_OFF) |-> !alarm_out[0])
		else $error("off alarm drives output");
	a_fault_unblocked: assert property (@(posedge clk) disable iff (!rst_b)
		(alarm_cfg[0].func == PA_AF_FAULT && sensor_fault_alarm && g_alarm[0].tstate == PA_TS_IDLE)
		|=> g_alarm[0].tstate != PA_TS_IDLE)
		else $error("fault alarm blocked");
	a_delay_holds: assert property (@(posedge clk) disable iff (!rst_b)
		(g_alarm[0].tstate == PA_TS_WAIT && !tick) |=> !alarm_out[0])
		else $error("delayed alarm drove early");
	a_analog_ch5: assert property (@(posedge clk) disable iff (!rst_b)
		(io_func_reg[7:4] >= PA_IO_AN_CTL1) |-> eff_func[1] == PA_IO_OFF)
		else $error("analog function off channel five");
	a_apb_answer: assert property (@(posedge clk) disable iff (!rst_b)
		(psel && !penable) |=> pready ##1 !pready)
		else $error("apb answer timing");
	a_remote_select: assert property (@(posedge clk) disable iff (!rst_b)
		(!next_prog1 && use_remote) |=> control_setpoint == $past(remote_setpoint))
		else $error("remote setpoint not selected");
	a_main_select: assert property (@(posedge clk) disable iff (!rst_b)
		(!next_prog1 && !use_remote) |=> control_setpoint == $past(main_setpoint))
		else $error("main setpoint not selected");
	a_stop_drive: assert property (@(posedge clk) disable iff (!rst_b)
		(!run_on ##1 !run_on) |=> ch_drive == 5'h00)
		else $error("channel driven while stopped");
	a_pulse_pins: assert property (@(posedge clk) disable iff (!rst_b)
		!ch_pulse_mode[0] && !ch_pulse_mode[1])
		else $error("pulse driver on relay-only channel");
endmodule : pa_alarm_io

// ===== tb/pa_plant.sv
// Far-side model: process sensor, fault lines, contacts, PID engine and profile engine.
// Assumes the bench moves its targets just after rising clock edges.
`timescale 1ns/1ps
module pa_plant import pa_pkg::*; #(
	parameter int SEG_CYCLES = 1000,
	parameter logic [9:0] PID_LEVEL = 10'h190
) (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic signed [15:0] pv_set,
	input wire logic [2:0] fault_set,
	input wire logic [4:0] contact_set,
	input wire logic break_set,
	input wire logic hold,
	output logic signed [15:0] process_value,
	output logic sensor_open,
	output logic sensor_range,
	output logic sensor_short,
	output logic signed [15:0] profile_setpoint,
	output logic profile_running,
	output logic [3:0] profile_segment,
	output logic [9:0] pid_power,
	output logic loop_break,
	output logic [4:0] di_closed
);
	logic [15:0] seg_count;
	// Field levels settle one clock after the bench asks, like a real sensor front end
	always_ff @(posedge clk) begin
		process_value <= pv_set;
		{sensor_short, sensor_range, sensor_open} <= fault_set;
		di_closed <= contact_set;
		loop_break <= break_set;
	end
	// Engines run free; the PID engine stays at one level so power selection is visible
	assign pid_power = PID_LEVEL;
	assign profile_running = 1'b1;
	// Ramp steps each cycle; hold freezes setpoint and segment where they stand
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			profile_setpoint <= 16'sh0000;
			profile_segment <= 4'h0;
			seg_count <= 16'h0000;
		end else if (!hold) begin
			profile_setpoint <= profile_setpoint + 16'sh0001;
			seg_count <= seg_count + 16'h0001;
			if (seg_count == 16'(SEG_CYCLES - 1)) begin
				seg_count <= 16'h0000;
				profile_segment <= (profile_segment == 4'h8) ? 4'h0 : profile_segment + 4'h1;
			end
		end
	end
endmodule : pa_plant

// ===== tb/tb.sv
// Self-checking bench for the alarm and I/O function block.
// Assumes the plant model on the far side and APB access to the registers.
`timescale 1ns/1ps
module tb import pa_pkg::*; ;
	logic clk = 1'b0;
	logic rst_b = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0000_0000;
	logic [31:0] prdata, rv, stv;
	logic pready, pslverr, er;
	logic signed [15:0] pv_set = 16'sh00C8;
	logic [2:0] fault_set = 3'h0;
	logic [4:0] contact_set = 5'h00;
	logic break_set = 1'b0;
	logic signed [15:0] process_value, profile_setpoint, control_setpoint;
	logic sensor_open, sensor_range, sensor_short, profile_running, loop_break;
	logic [3:0] profile_segment, analog_func, alarm_lamp;
	logic [9:0] pid_power, power_one, power_two;
	logic [4:0] di_closed, ch_drive, ch_pulse_mode;
	logic manual_active, profile_hold, first_profile_select;
	int bad_count = 0;
	int comparisons = 0;
	int n_on, t_on;
	// Alarm cases: func, fault lines, segment mask, lamp, threshold, value (setpoint 200)
	localparam logic [47:0] ALM [19] = '{48'h3001_0064_0032, 48'h3000_0064_0064, 48'h4001_0064_0065,
		48'h4000_0064_0064, 48'h5001_0014_00DD, 48'h5000_0014_00DC, 48'h5001_FFEC_00D2,
		48'h5000_FFEC_00E6, 48'h6001_000A_00BD, 48'h6000_000A_00BE, 48'h7001_000A_00D3,
		48'h7000_000A_00D2, 48'h0000_0000_0000, 48'h1101_0000_00C8, 48'h1201_0000_00C8,
		48'h1401_0000_00C8, 48'h1000_0000_00C8, 48'h2011_0000_00C8, 48'h2020_0000_00C8};
	// Timer modes: direct, single pulse, delayed, repeated; with 10-cycle ticks
	localparam logic [31:0] TIMES [4] = '{32'h0, 32'h0000_0002, 32'h0002_0000, 32'h0002_0002};
	localparam int ON_LO [4] = '{74, 18, 46, 28};
	localparam int ON_HI [4] = '{80, 32, 62, 52};
	localparam int F_HI [4] = '{4, 4, 34, 4};
	localparam int F_LO [4] = '{0, 0, 18, 0};

	pa_alarm_io #(.TICK_CYCLES(10)) DUT (.clk(clk), .rst_b(rst_b), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .process_value(process_value), .sensor_open(sensor_open),
		.sensor_range(sensor_range), .sensor_short(sensor_short), .profile_setpoint(profile_setpoint),
		.profile_running(profile_running), .profile_segment(profile_segment), .pid_power(pid_power),
		.loop_break(loop_break), .di_closed(di_closed), .ch_drive(ch_drive), .ch_pulse_mode(ch_pulse_mode),
		.analog_func(analog_func), .alarm_lamp(alarm_lamp), .power_one(power_one), .power_two(power_two),
		.control_setpoint(control_setpoint), .manual_active(manual_active), .profile_hold(profile_hold),
		.first_profile_select(first_profile_select));
	pa_plant plant (.clk(clk), .rst_b(rst_b), .pv_set(pv_set), .fault_set(fault_set),
		.contact_set(contact_set), .break_set(break_set), .hold(profile_hold),
		.process_value(process_value), .sensor_open(sensor_open), .sensor_range(sensor_range),
		.sensor_short(sensor_short), .profile_setpoint(profile_setpoint), .profile_running(profile_running),
		.profile_segment(profile_segment), .pid_power(pid_power), .loop_break(loop_break),
		.di_closed(di_closed));

	// 200 MHz clock
	always #2.5 clk = ~clk;

	task automatic print_verdict;
		$display("comparisons %0d mismatches %0d", comparisons, bad_count);
		if (bad_count == 0 && comparisons > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask : print_verdict

	task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
		comparisons++;
		if (got !== exp) begin
			bad_count++;
			$display("wrong value %s expected %h seen %h", name, exp, got);
		end
	endtask : chk

	task automatic tick(input int n);
		repeat (n) @(posedge clk);
	endtask : tick

	// One APB transfer, entered just after an edge; idles a cycle after release
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
		int n;
		n = 0;
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= wd;
		@(posedge clk);
		penable <= 1'b1;
		do begin
			@(posedge clk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		if (n >= 20) begin
			bad_count++;
			print_verdict();
		end
		rv = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clk);
	endtask : apb

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
		tick(4);
	endtask : wr

	initial begin
		tick(6);
		rst_b <= 1'b1;
		@(posedge clk);
		apb(1'b0, PA_ADDR_CTRL, 32'h0);
		chk("ctrl reset", PA_CTRL_RESET, rv);
		apb(1'b0, 8'h40, 32'h0);
		chk("unmapped error", 32'h1, 32'(er));
		chk("unmapped data", 32'h0, rv);
		wr(PA_ADDR_SETPT, 32'h012C_00C8);
		foreach (ALM[i]) begin
			fault_set <= ALM[i][42:40];
			pv_set <= ALM[i][15:0];
			wr(PA_ADDR_ALCFG0, {ALM[i][31:16], 8'h00, ALM[i][39:36], 1'b0, ALM[i][46:44]});
			chk("lamp", 32'(ALM[i][32]), 32'(alarm_lamp[0]));
		end
		fault_set <= 3'h0;
		$display("test alarm functions finished");
		// Low alarm at 100 routed to channel one, through each timer mode
		wr(PA_ADDR_ALCFG0, 32'h0064_0003);
		wr(PA_ADDR_IOFUNC, 32'h0000_0001);
		for (int m = 0; m < 4; m++) begin
			pv_set <= 16'sh00C8;
			wr(PA_ADDR_ALTIM0, TIMES[m]);
			tick(40);
			pv_set <= 16'sh0032;
			n_on = 0;
			t_on = 99;
			for (int c = 0; c < 80; c++) begin
				@(posedge clk);
				if (ch_drive[0] === 1'b1) begin
					n_on++;
					if (t_on == 99) t_on = c;
				end
			end
			chk("on cycles", 32'h1, 32'(n_on >= ON_LO[m] && n_on <= ON_HI[m]));
			chk("first on", 32'h1, 32'(t_on >= F_LO[m] && t_on <= F_HI[m]));
			chk("lamp held", 32'h1, 32'(alarm_lamp[0]));
		end
		wr(PA_ADDR_ALTIM0, 32'h0);
		chk("alarm out", 32'h1, 32'(ch_drive[0]));
		wr(PA_ADDR_CTRL, 32'h0);
		chk("stopped out", 32'h0, 32'(ch_drive));
		chk("stopped lamp", 32'h1, 32'(alarm_lamp[0]));
		$display("test alarm timers finished");
		// Remote, run and auto/manual contacts; loop break on channel two
		wr(PA_ADDR_CTRL, 32'h5);
		wr(PA_ADDR_TUNE, 32'h012C_0032);
		break_set <= 1'b1;
		contact_set <= 5'b11100;
		wr(PA_ADDR_IOFUNC, 32'h0008_9A51);
		chk("remote sp", 32'h012C, 32'(control_setpoint));
		chk("manual", 32'h1, 32'(manual_active));
		chk("manual power", 32'h012C, 32'(power_one));
		chk("manual two", 32'h0, 32'(power_two));
		chk("loop break", 32'h1, 32'(ch_drive[1]));
		contact_set <= 5'b01000;
		tick(4);
		chk("main sp", 32'h00C8, 32'(control_setpoint));
		chk("auto", 32'h0, 32'(manual_active));
		chk("auto power", 32'h0190, 32'(power_one));
		wr(PA_ADDR_TUNE, 32'h012C_0000);
		chk("onoff full", 32'h03E8, 32'(power_one));
		pv_set <= 16'sh00FA;
		tick(4);
		chk("onoff zero", 32'h0, 32'(power_one));
		chk("cool full", 32'h03E8, 32'(power_two));
		contact_set <= 5'b00000;
		tick(4);
		chk("run off power", 32'h0, 32'(power_two));
		chk("run off drive", 32'h0, 32'(ch_drive));
		$display("test contacts finished");
		// Hold and program-one contacts, analog control on channel five
		pv_set <= 16'sh0032;
		contact_set <= 5'b01100;
		wr(PA_ADDR_IOFUNC, 32'h000D_CB51);
		chk("prog one", 32'h1, 32'(first_profile_select));
		chk("analog", 32'hD, 32'(analog_func));
		contact_set <= 5'b01000;
		tick(6);
		stv = 32'(control_setpoint);
		chk("hold", 32'h1, 32'(profile_hold));
		chk("profile sp", 32'(profile_setpoint), stv);
		tick(10);
		chk("frozen sp", stv, 32'(control_setpoint));
		contact_set <= 5'b01100;
		tick(6);
		chk("resumed", 32'h1, 32'(32'(control_setpoint) !== stv));
		contact_set <= 5'b00100;
		tick(4);
		chk("main again", 32'h00C8, 32'(control_setpoint));
		$display("test profile finished");
		// Pulse drivers on channels three and five with the option fitted, on channel five alone without it
		wr(PA_ADDR_IOFUNC, 32'h0006_0606);
		chk("pulse option", 32'h14, 32'(ch_pulse_mode));
		chk("relay drive", 32'h1, 32'(ch_drive[0]));
		wr(PA_ADDR_CTRL, 32'h1);
		chk("pulse plain", 32'h10, 32'(ch_pulse_mode));
		contact_set <= 5'b00000;
		wr(PA_ADDR_IOFUNC, 32'h000F_00DB);
		chk("retransmit", 32'hF, 32'(analog_func));
		chk("no hold on ch1", 32'h0, 32'(profile_hold));
		$display("test channel limits finished");
		print_verdict();
	end
endmodule : tb
